// ===== phwi_host_model.sv
module phwi_host_model
(
    input wire logic mclk,
    input wire logic rx_bit_clock,
    input wire logic rx_data,
    input wire logic tx_bit_clock,
    output logic tx_data,
    output logic [7:0] rx_got,
    output logic rx_done
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] TX_PAT = 8'hc5;
    logic rx_q = 1'b0;
    logic tx_q = 1'b0;
    logic [3:0] rx_cnt = 4'h0;
    logic [2:0] tx_idx = 3'h0;
    initial
    begin
        tx_data = TX_PAT[0];
        rx_got = 8'h00;
        rx_done = 1'b0;
    end
    always @(posedge mclk)
    begin
        rx_q <= rx_bit_clock;
        tx_q <= tx_bit_clock;
        // sample mid-bit, well clear of the launch edge
        if (rx_q && !rx_bit_clock && !rx_done && (rx_cnt != 4'h0 || !rx_data))
        begin
            rx_got <= {rx_data, rx_got[7:1]};
            rx_cnt <= rx_cnt + 4'h1;
            rx_done <= rx_cnt == 4'h7;
        end
        if (tx_q && !tx_bit_clock)
        begin
            tx_idx <= tx_idx + 3'h1;
            tx_data <= TX_PAT[tx_idx + 3'h1];
        end
    end
endmodule // phwi_host_model

// ===== phwi_pkg.sv
// How it works
// - host clock divided per bits 11-9
// - reset pin high resets everything, control word to PHWI_CW_RESET
// - terminal wake low requests power-up, mask1
// - call alert low requests power-up, mask0
// - wake output latched until low-byte write
// - strobes count only with chip select
// - read strobe drives, write strobe captures
// - two-bit address, eight-bit data bus
// - irq on core mailbox write, clears on mailbox low-byte (addr 3) read
// - receive bit launched on rx clock rise
// - transmit bit sampled on tx clock rise
// - software enters idle through control word
// - terminal equipment may request power-down
// - enables gate core, host clock, oscillator
// - wake, reset and control bits set power
// - addr 0/1 control word, 2/3 mailbox
// - serial data least significant bit first
// - control write flags core, no response
package phwi_pkg;
    localparam logic [1:0] PHWI_A_CW_HI = 2'h0;
    localparam logic [1:0] PHWI_A_CW_LO = 2'h1;
    localparam logic [1:0] PHWI_A_MB_HI = 2'h2;
    localparam logic [1:0] PHWI_A_MB_LO = 2'h3;
    localparam logic [15:0] PHWI_CW_RESET = 16'hfeb1;
    localparam int PHWI_B_RUN = 0;
    localparam int PHWI_B_MASK0 = 1;
    localparam int PHWI_B_MASK1 = 2;
    localparam int PHWI_B_SOFTRST = 3;
    localparam int PHWI_B_OSC = 7;
    localparam int PHWI_B_HCLKEN = 8;
    localparam int PHWI_B_HDIV = 9;
    localparam int PHWI_B_CORECLK = 12;
    localparam int PHWI_B_CDIV = 13;
    localparam logic [2:0] PHWI_MASK_KEEP = 3'h6;
    // serial bit clock half period, in mclk cycles
    localparam logic [7:0] PHWI_BIT_HALF = 8'h14;
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [1:0] addr;
        logic [7:0] data;
    } phwi_host_t;
    typedef enum logic [1:0] {
        PHWI_ST_RUN = 2'b00,
        PHWI_ST_IDLE = 2'b01,
        PHWI_ST_SLEEP = 2'b10
    } phwi_pwr_t;
endpackage

// ===== phwi_top.sv
module phwi_top
    import phwi_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [1:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_n,
    output logic host_irq_n,
    input wire logic terminal_wake_n,
    input wire logic call_alert_n,
    input wire logic dte_sleep_req,
    input wire logic slave_mode,
    output logic wake_n,
    output logic host_clock_out,
    output logic rx_bit_clock,
    output logic rx_data,
    output logic tx_bit_clock,
    input wire logic tx_data,
    input wire logic core_mb_wr,
    input wire logic [15:0] core_mb_wdata,
    output logic [15:0] core_mb_rdata,
    output logic core_mb_new,
    input wire logic core_cw_ack,
    output logic [15:0] control_word_0,
    output logic cw_written,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_valid,
    output logic rx_byte_taken,
    output logic [7:0] tx_byte,
    output logic tx_byte_valid,
    output logic [1:0] power_state
);
    // three-stage synchronisers: cs, rd, wr, terminal, alert, sleep
    logic [5:0] s1, s2, s3;
    wire [5:0] raw_in = {dte_sleep_req, call_alert_n, terminal_wake_n,
        host_wr_n, host_rd_n, host_cs_n};
    logic [5:0] stable;
    logic [7:0] din_q;
    logic [1:0] addr_q;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // idle levels: strobes and wakes high, sleep request low
            s1 <= 6'h1f;
            s2 <= 6'h1f;
            s3 <= 6'h1f;
            stable <= 6'h1f;
        end
        else if (clk_en)
        begin
            s1 <= raw_in;
            s2 <= s1;
            s3 <= s2;
            // per bit, so one input in transition never blocks the others
            stable <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & stable);
        end
    end
    // address and data sampled while the strobe settles
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            din_q <= 8'h00;
            addr_q <= 2'h0;
        end
        else if (clk_en)
        begin
            din_q <= host_data_in;
            addr_q <= host_addr;
        end
    end
    logic [5:0] prev;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            prev <= 6'h1f;
        else if (clk_en)
            prev <= stable;
    end
    wire sel = ~stable[0];
    wire rd_act = sel & ~stable[1];
    wire wr_fall = sel & ~stable[2] & prev[2];
    wire rd_rise = stable[1] & ~prev[1] & ~prev[0];
    wire term_req = ~stable[3] & ~control_word_0[PHWI_B_MASK1];
    wire alert_req = ~stable[4] & ~control_word_0[PHWI_B_MASK0];
    wire wake_req = term_req | alert_req;
    wire wr_cw_hi = wr_fall & (addr_q == PHWI_A_CW_HI);
    wire wr_cw_lo = wr_fall & (addr_q == PHWI_A_CW_LO);
    wire wr_mb_hi = wr_fall & (addr_q == PHWI_A_MB_HI);
    wire wr_mb_lo = wr_fall & (addr_q == PHWI_A_MB_LO);
    wire soft_rst = wr_cw_lo & din_q[PHWI_B_SOFTRST];
    // soft reset keeps the wake mask, as the pin reset does not
    wire [15:0] soft_val = {PHWI_CW_RESET[15:3],
        control_word_0[2:1], PHWI_CW_RESET[0]};
    wire [15:0] next_cw = soft_rst ? soft_val :
        wr_cw_hi ? {din_q, control_word_0[7:0]} :
        wr_cw_lo ? {control_word_0[15:8], din_q} : control_word_0;
    // control word and flag to the core
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            control_word_0 <= PHWI_CW_RESET;
            cw_written <= 1'b0;
        end
        else if (clk_en)
        begin
            control_word_0 <= next_cw;
            // set wins over the core acknowledge
            if (wr_cw_hi | wr_cw_lo)
                cw_written <= 1'b1;
            else if (core_cw_ack)
                cw_written <= 1'b0;
        end
    end
    // mailbox: host writes go to the core, core writes raise irq
    logic [15:0] mb_to_host;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mb_to_host <= 16'h0000;
            core_mb_rdata <= 16'h0000;
            core_mb_new <= 1'b0;
            host_irq_n <= 1'b1;
        end
        else if (clk_en)
        begin
            if (core_mb_wr)
                mb_to_host <= core_mb_wdata;
            if (wr_mb_hi)
                core_mb_rdata[15:8] <= din_q;
            if (wr_mb_lo)
                core_mb_rdata[7:0] <= din_q;
            core_mb_new <= wr_mb_lo;
            if (core_mb_wr)
                host_irq_n <= 1'b0;
            else if (rd_rise & (addr_q == PHWI_A_MB_LO))
                host_irq_n <= 1'b1;
        end
    end
    // read path: addresses 0 and 1 are write only and read as zero
    wire [7:0] rd_mux = (addr_q == PHWI_A_MB_HI) ? mb_to_host[15:8] :
        (addr_q == PHWI_A_MB_LO) ? mb_to_host[7:0] : 8'h00;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            host_data_out <= 8'h00;
            host_data_oe_n <= 1'b1;
        end
        else if (clk_en)
        begin
            host_data_out <= rd_mux;
            host_data_oe_n <= ~rd_act;
        end
    end
    // wake latch: only in slave mode, cleared by low byte write
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            wake_n <= 1'b1;
        else if (clk_en)
        begin
            if (slave_mode & wake_req)
                wake_n <= 1'b0;
            else if (wr_cw_lo)
                wake_n <= 1'b1;
        end
    end
    // power state
    phwi_pwr_t pwr;
    wire clk_all_off = ~control_word_0[PHWI_B_CORECLK] &
        ~control_word_0[PHWI_B_HCLKEN] & ~control_word_0[PHWI_B_OSC];
    phwi_pwr_t next_pwr;
    always_comb
    begin
        next_pwr = pwr;
        case (pwr)
            PHWI_ST_RUN:
                if (~control_word_0[PHWI_B_RUN] | stable[5])
                    next_pwr = PHWI_ST_IDLE;
            PHWI_ST_IDLE:
                if (wake_req)
                    next_pwr = PHWI_ST_RUN;
                else if (clk_all_off | stable[5])
                    next_pwr = PHWI_ST_SLEEP;
                else if (control_word_0[PHWI_B_RUN])
                    next_pwr = PHWI_ST_RUN;
            PHWI_ST_SLEEP:
                if (wake_req | ~clk_all_off)
                    next_pwr = PHWI_ST_RUN;
            default:
                next_pwr = PHWI_ST_RUN;
        endcase
    end
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pwr <= PHWI_ST_RUN;
            power_state <= 2'h0;
        end
        else if (clk_en)
        begin
            pwr <= next_pwr;
            power_state <= next_pwr;
        end
    end
    // host clock: toggles every (8-div) cycles; divisor 0 is slowest
    logic [2:0] hdiv_cnt;
    wire [2:0] hdiv = control_word_0[PHWI_B_HDIV +: 3];
    wire [2:0] hdiv_lim = ~hdiv;
    wire hclk_on = control_word_0[PHWI_B_HCLKEN] &
        control_word_0[PHWI_B_OSC];
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hdiv_cnt <= 3'h0;
            host_clock_out <= 1'b0;
        end
        else if (clk_en)
        begin
            if (~hclk_on)
            begin
                hdiv_cnt <= 3'h0;
                host_clock_out <= 1'b0;
            end
            else if (hdiv_cnt >= hdiv_lim)
            begin
                hdiv_cnt <= 3'h0;
                host_clock_out <= ~host_clock_out;
            end
            else
                hdiv_cnt <= hdiv_cnt + 3'h1;
        end
    end
    // serial channel: one bit clock drives both directions
    logic [7:0] bit_cnt;
    logic [2:0] rx_idx, tx_idx;
    logic [7:0] rx_sh, tx_sh;
    logic rx_busy;
    wire ser_on = (pwr == PHWI_ST_RUN);
    wire half = (bit_cnt == PHWI_BIT_HALF - 8'h1);
    wire rise = half & ~rx_bit_clock & ser_on;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bit_cnt <= 8'h00;
            rx_bit_clock <= 1'b0;
            tx_bit_clock <= 1'b0;
        end
        else if (clk_en)
        begin
            bit_cnt <= (half | ~ser_on) ? 8'h00 : bit_cnt + 8'h1;
            if (ser_on & half)
            begin
                rx_bit_clock <= ~rx_bit_clock;
                tx_bit_clock <= ~tx_bit_clock;
            end
        end
    end
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_sh <= 8'h00;
            rx_idx <= 3'h0;
            rx_busy <= 1'b0;
            rx_data <= 1'b1;
            rx_byte_taken <= 1'b0;
            tx_sh <= 8'h00;
            tx_idx <= 3'h0;
            tx_byte <= 8'h00;
            tx_byte_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_byte_taken <= 1'b0;
            tx_byte_valid <= 1'b0;
            if (rise)
            begin
                // launch next bit with the rising edge; idle line is high
                if (rx_busy)
                begin
                    rx_data <= rx_sh[rx_idx];
                    rx_idx <= rx_idx + 3'h1;
                    rx_busy <= (rx_idx != 3'h7);
                end
                else if (rx_byte_valid)
                begin
                    rx_data <= rx_byte[0];
                    rx_sh <= rx_byte;
                    rx_idx <= 3'h1;
                    rx_busy <= 1'b1;
                    rx_byte_taken <= 1'b1;
                end
                else
                    rx_data <= 1'b1;
                // tx_data comes from host logic on the same clock
                tx_sh[tx_idx] <= tx_data;
                tx_idx <= tx_idx + 3'h1;
                if (tx_idx == 3'h7)
                begin
                    tx_byte <= {tx_data, tx_sh[6:0]};
                    tx_byte_valid <= 1'b1;
                end
            end
        end
    end
endmodule // phwi_top

// ===== phwi_top_asserts.sv
module phwi_top_asserts
    import phwi_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic core_mb_wr,
    input wire logic host_irq_n,
    input wire logic host_data_oe_n,
    input wire logic terminal_wake_n,
    input wire logic call_alert_n,
    input wire logic slave_mode,
    input wire logic wake_n,
    input wire logic rx_bit_clock,
    input wire logic tx_bit_clock,
    input wire logic [15:0] control_word_0,
    input wire logic [1:0] power_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire run = power_state == PHWI_ST_RUN;
    property p_rst_cw;
        $fell(sys_rst) |-> control_word_0 == PHWI_CW_RESET;
    endproperty
    a_rst_cw: assert property (p_rst_cw) else $error("cw reset value");
    property p_irq_set;
        core_mb_wr |=> !host_irq_n;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq not set");
    property p_twake;
        (slave_mode && !terminal_wake_n && !control_word_0[PHWI_B_MASK1])[*6]
        |-> !wake_n;
    endproperty
    a_twake: assert property (p_twake) else $error("terminal wake");
    property p_cwake;
        (slave_mode && !call_alert_n && !control_word_0[PHWI_B_MASK0])[*6]
        |-> !wake_n;
    endproperty
    a_cwake: assert property (p_cwake) else $error("call wake");
    property p_wake_clr;
        $rose(wake_n) |-> !$past(host_wr_n, 2) && !$past(host_cs_n, 2);
    endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wake clr");
    property p_oe;
        $fell(host_data_oe_n) |-> !$past(host_rd_n, 2) && !$past(host_cs_n, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven unasked");
    property p_cw_chg;
        $changed(control_word_0) |-> !$past(host_wr_n, 2) && !$past(host_cs_n, 2);
    endproperty
    a_cw_chg: assert property (p_cw_chg) else $error("cw changed");
    property p_bitclk;
        $rose(rx_bit_clock) |-> tx_bit_clock ##19 (rx_bit_clock || !run)
        ##1 (!rx_bit_clock || !run);
    endproperty
    a_bitclk: assert property (p_bitclk) else $error("bit clock");
endmodule // phwi_top_asserts

// ===== tb_phwi_top.sv
module tb_phwi_top;
    import phwi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, sys_rst = 1'b1;
    logic host_cs_n = 1'b1, host_rd_n = 1'b1, host_wr_n = 1'b1;
    logic [1:0] host_addr = 2'h0;
    logic [7:0] hd_drv = 8'h00, host_data_out, rx_byte = 8'h00;
    logic [7:0] tx_byte, rx_got, tx_first = 8'h00;
    logic terminal_wake_n = 1'b1, call_alert_n = 1'b1, dte_sleep_req = 1'b0;
    logic slave_mode = 1'b0, core_mb_wr = 1'b0, core_cw_ack = 1'b0;
    logic rx_byte_valid = 1'b0, tx_seen = 1'b0, prev;
    logic [15:0] core_mb_wdata = 16'h0000, core_mb_rdata, control_word_0;
    logic host_data_oe_n, host_irq_n, wake_n, host_clock_out, rx_bit_clock;
    logic rx_data, tx_bit_clock, tx_data, core_mb_new, cw_written, rx_done;
    logic rx_byte_taken, tx_byte_valid;
    logic [1:0] power_state;
    int fail_count = 0, num_checks = 0, cycles = 0, new_seen = 0;
    // released bus floats: model it as the inverse of the last value
    wire [7:0] host_data_in = host_data_oe_n ? hd_drv : host_data_out;
    phwi_top i_dut (.mclk, .sys_rst, .clk_en(1'b1), .host_cs_n, .host_rd_n,
        .host_wr_n, .host_addr, .host_data_in, .host_data_out,
        .host_data_oe_n, .host_irq_n, .terminal_wake_n, .call_alert_n,
        .dte_sleep_req, .slave_mode, .wake_n, .host_clock_out, .rx_bit_clock,
        .rx_data, .tx_bit_clock, .tx_data, .core_mb_wr, .core_mb_wdata,
        .core_mb_rdata, .core_mb_new, .core_cw_ack, .control_word_0,
        .cw_written, .rx_byte, .rx_byte_valid, .rx_byte_taken, .tx_byte,
        .tx_byte_valid, .power_state);
    phwi_host_model i_host (.mclk, .rx_bit_clock, .rx_data, .tx_bit_clock,
        .tx_data, .rx_got, .rx_done);
    initial
    begin
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles++;
        new_seen += int'(core_mb_new === 1'b1);
        if (tx_byte_valid === 1'b1 && !tx_seen)
        begin
            tx_first <= tx_byte;
            tx_seen <= 1'b1;
        end
        if (cycles == 30000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // strobes stay low and high six cycles, above the four needed
    task automatic hwr(input logic cs, input logic [1:0] a, input logic [7:0] d);
        host_cs_n <= cs;
        host_addr <= a;
        hd_drv <= d;
        host_wr_n <= 1'b0;
        tick(6);
        host_wr_n <= 1'b1;
        host_cs_n <= 1'b1;
        tick(6);
        hd_drv <= ~d;
    endtask
    task automatic hrd(input logic [1:0] a, input logic [7:0] exp);
        host_cs_n <= 1'b0;
        host_addr <= a;
        host_rd_n <= 1'b0;
        tick(6);
        chk(16'(host_data_oe_n), 16'h0000);
        chk({8'h00, host_data_out}, {8'h00, exp});
        host_rd_n <= 1'b1;
        host_cs_n <= 1'b1;
        tick(6);
    endtask
    task automatic hclk(input logic [7:0] hi, input int half);
        int n;
        n = 0;
        hwr(1'b0, PHWI_A_CW_HI, hi);
        repeat (32 * half)
        begin
            prev = host_clock_out;
            tick(1);
            n += int'(host_clock_out === 1'b1 && prev === 1'b0);
        end
        chk(16'(n), 16'h0010);
    endtask
    task automatic wk(input bit t, input logic exp);
        if (t)
            terminal_wake_n <= 1'b0;
        else
            call_alert_n <= 1'b0;
        tick(10);
        terminal_wake_n <= 1'b1;
        call_alert_n <= 1'b1;
        tick(10);
        chk(16'(wake_n), 16'(exp));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        tick(5);
        sys_rst <= 1'b0;
        tick(2);
        chk(control_word_0, PHWI_CW_RESET);
        chk(16'({host_irq_n, wake_n, host_data_oe_n}), 16'h0007);
        hwr(1'b1, PHWI_A_CW_LO, 8'h00);
        chk(control_word_0, PHWI_CW_RESET);
        chk(16'(cw_written), 16'h0000);
        hclk(8'hf1, 8);
        chk(control_word_0, 16'hf1b1);
        chk(16'(cw_written), 16'h0001);
        core_cw_ack <= 1'b1;
        tick(1);
        core_cw_ack <= 1'b0;
        tick(2);
        chk(16'(cw_written), 16'h0000);
        hclk(8'hf7, 5);
        $display("control word and host clock done");
        rx_byte <= 8'h96;
        rx_byte_valid <= 1'b1;
        while (rx_byte_taken !== 1'b1)
            tick(1);
        rx_byte_valid <= 1'b0;
        while (rx_done !== 1'b1)
            tick(1);
        chk({8'h00, rx_got}, 16'h0096);
        chk({8'h00, tx_first}, 16'h00c5);
        $display("serial done");
        hwr(1'b0, PHWI_A_MB_HI, 8'ha5);
        hwr(1'b0, PHWI_A_MB_LO, 8'h5a);
        chk(core_mb_rdata, 16'ha55a);
        chk(16'(new_seen), 16'h0001);
        hrd(PHWI_A_CW_HI, 8'h00);
        core_mb_wdata <= 16'hc33c;
        core_mb_wr <= 1'b1;
        tick(1);
        core_mb_wr <= 1'b0;
        tick(1);
        chk(16'(host_irq_n), 16'h0000);
        hrd(PHWI_A_MB_HI, 8'hc3);
        chk(16'(host_irq_n), 16'h0000);
        hrd(PHWI_A_MB_LO, 8'h3c);
        chk(16'(host_irq_n), 16'h0001);
        $display("mailbox done");
        hwr(1'b0, PHWI_A_CW_LO, 8'h37);
        chk(control_word_0, 16'hf737);
        hwr(1'b0, PHWI_A_CW_LO, 8'h08);
        chk(control_word_0, 16'hfeb7);
        slave_mode <= 1'b1;
        wk(1'b1, 1'b1);
        wk(1'b0, 1'b1);
        hwr(1'b0, PHWI_A_CW_LO, 8'h35);
        wk(1'b1, 1'b1);
        wk(1'b0, 1'b0);
        hwr(1'b0, PHWI_A_CW_LO, 8'h33);
        chk(16'(wake_n), 16'h0001);
        wk(1'b0, 1'b1);
        wk(1'b1, 1'b0);
        hwr(1'b0, PHWI_A_CW_LO, 8'h30);
        chk(16'(power_state), 16'(PHWI_ST_IDLE));
        hwr(1'b0, PHWI_A_CW_HI, 8'he0);
        chk(16'(power_state), 16'(PHWI_ST_SLEEP));
        hwr(1'b0, PHWI_A_CW_LO, 8'h31);
        hwr(1'b0, PHWI_A_CW_HI, 8'hf1);
        chk(16'(power_state), 16'(PHWI_ST_RUN));
        dte_sleep_req <= 1'b1;
        tick(8);
        chk(16'(power_state), 16'(PHWI_ST_IDLE));
        dte_sleep_req <= 1'b0;
        wk(1'b0, 1'b0);
        chk(16'(power_state), 16'(PHWI_ST_RUN));
        $display("wake and power done");
        tally_and_finish();
    end
endmodule // tb_phwi_top
bind phwi_top phwi_top_asserts i_chk (.mclk, .sys_rst, .host_cs_n,
    .host_rd_n, .host_wr_n, .core_mb_wr, .host_irq_n, .host_data_oe_n,
    .terminal_wake_n, .call_alert_n, .slave_mode, .wake_n, .rx_bit_clock,
    .tx_bit_clock, .control_word_0, .power_state);
